// *** rtl/ufi_pkg.sv ***
// Package of constants and types for the frame number and interrupt flags.
// Functional notes
// - Frame number readable at 0x0C low, 0x0D high.
// - Flag registers ignore software writes entirely.
// - Enables live in their own separate registers.
// - Any set flag raises gated combined interrupt.
// - Reading a flag register returns then clears.
// - IN flags at 0x02, four low bits used.
// - SOF flag in common flags at 0x06.
// - IN enables at 0x07, reset to all ones.
package ufi_pkg;
  // Byte offsets of the registers on the bus.
  localparam logic [7:0] ADDR_IN_FLAGS = 8'h02;
  localparam logic [7:0] ADDR_CM_FLAGS = 8'h06;
  localparam logic [7:0] ADDR_IN_EN = 8'h07;
  localparam logic [7:0] ADDR_CM_EN = 8'h0B;
  localparam logic [7:0] ADDR_FRAME_LO = 8'h0C;
  localparam logic [7:0] ADDR_FRAME_HI = 8'h0D;
  localparam logic [7:0] ADDR_CPU_EN = 8'h10;
  // Field positions.
  localparam int SOF_BIT = 3;
  // Reset values.
  localparam logic [3:0] IN_EN_RST = 4'hF;
  localparam logic [3:0] CM_EN_RST = 4'h8;
  localparam logic CPU_EN_RST = 1'b0;

  // Whole state of the block.
  typedef struct packed {
    logic [10:0] frame_r;     // Last received frame number.
    logic [3:0] in_flags_r;   // IN endpoint 3..1 and control endpoint.
    logic [3:0] cm_flags_r;   // Common flags, SOF at bit 3.
    logic [3:0] in_en_r;      // IN flag enables.
    logic [3:0] cm_en_r;      // Common flag enables.
    logic cpu_en_r;           // Processor side interrupt enable.
    logic [31:0] rdata_r;     // Read data to the bus.
    logic rvalid_r;           // Answer cycle marker.
    logic irq_r;              // Registered interrupt request.
  } ufi_state_t;

  // Hardware event inputs grouped together.
  typedef struct packed {
    logic sof;                // Valid start of frame received.
    logic [10:0] frame;       // Frame number carried by that SOF.
    logic [3:0] in_ev;        // IN endpoint events, bit 0 control.
    logic [2:0] cm_ev;        // Reset, resume and suspend events.
  } ufi_events_t;
endpackage : ufi_pkg

// *** rtl/ufi_core.sv ***
// Frame number capture and USB interrupt flag logic with Avalon-MM slave.
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/10ps
module ufi_core
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire ufi_pkg::ufi_events_t i_ev,
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic o_irq
);
  // Overview of the block.
  // The block keeps the frame number of the most recent start of frame
  // and the interrupt flags of the IN endpoints and of the common events.
  // Software reaches every register over the slave port, one byte per
  // word address, with the byte in bits 7 to 0 and zero above it.
  // Every request takes exactly two cycles: the first cycle launches
  // the read data, and in the second cycle waitrequest is low.
  // A master that holds its request until it sees waitrequest low will
  // therefore always see the answer in the cycle after it asked.
  //
  // Flag registers are cleared by the read that returns them.
  // The clear happens at the edge that ends the answer cycle.
  // The value handed back is the one seen when the read was taken.
  // An event that arrives in the same cycle as the clear survives it.
  // This keeps a poll from losing an answer-cycle event; one in the request cycle is cleared unseen.
  //
  // The interrupt request is registered, but it is computed from the next
  // flags and enables, so it changes at the same edge as they do.
  // It is gated first by the per-source enables and then by the single
  // processor-side enable, which is off after reset.
  //
  // Hazard: the flag registers ignore every write, including writes
  // of ones; a driver that expects write-one-to-clear will not work.
  // Limitation: only byte lane 0 of a write is used; other lanes are
  // dropped without any error response.
  // Limitation: unmapped addresses read as zero and ignore writes.
  //
  // Current and next state.
  ufi_pkg::ufi_state_t st_r;
  ufi_pkg::ufi_state_t st_nxt;
  // A request is answered in its second cycle; waitrequest is low then.
  logic rd_hit;
  logic wr_hit;

  // Readback decoder, shared by the read path.
  // It maps a byte address onto the register that lives there.
  // Unused upper bits of every register are filled with zeros here.
  // The high frame byte carries only the top three frame bits.
  // Addresses that hold no register return zero.
  function automatic logic [7:0] rd_mux(input ufi_pkg::ufi_state_t s,
                                        input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      ufi_pkg::ADDR_IN_FLAGS: v = {4'h0, s.in_flags_r};
      ufi_pkg::ADDR_CM_FLAGS: v = {4'h0, s.cm_flags_r};
      ufi_pkg::ADDR_IN_EN: v = {4'h0, s.in_en_r};
      ufi_pkg::ADDR_CM_EN: v = {4'h0, s.cm_en_r};
      ufi_pkg::ADDR_FRAME_LO: v = s.frame_r[7:0];
      ufi_pkg::ADDR_FRAME_HI: v = {5'h00, s.frame_r[10:8]};
      ufi_pkg::ADDR_CPU_EN: v = {7'h00, s.cpu_en_r};
      default: v = 8'h00;
    endcase
    return v;
  endfunction : rd_mux

  // The answer cycle is the one after the request was first seen.
  assign rd_hit = i_avs_read && st_r.rvalid_r;
  assign wr_hit = i_avs_write && st_r.rvalid_r;

  // Next state computation.
  // The order of the steps below matters: clears come first, then the
  // hardware events are ORed in, so that an event wins over a clear.
  // The interrupt is computed last from the next values, so it tracks
  // the flags and enables that will stand after this edge.
  always_comb
  begin
    st_nxt = st_r;
    // Toggle answer marker so each request takes exactly two cycles.
    st_nxt.rvalid_r = (i_avs_read || i_avs_write) && !st_r.rvalid_r;
    // Read data is presented during the answer cycle.
    if (i_avs_read && !st_r.rvalid_r)
    begin
      st_nxt.rdata_r = {24'h000000, rd_mux(st_r, i_avs_address)};
    end
    if (i_ev.sof)
    begin
      st_nxt.frame_r = i_ev.frame;
    end
    if (rd_hit && i_avs_address == ufi_pkg::ADDR_IN_FLAGS)
    begin
      st_nxt.in_flags_r = 4'h0;
    end
    if (rd_hit && i_avs_address == ufi_pkg::ADDR_CM_FLAGS)
    begin
      st_nxt.cm_flags_r = 4'h0;
    end
    st_nxt.in_flags_r = st_nxt.in_flags_r | i_ev.in_ev;
    st_nxt.cm_flags_r = st_nxt.cm_flags_r | {i_ev.sof, i_ev.cm_ev};
    if (wr_hit && i_avs_byteenable[0])
    begin
      unique case (i_avs_address)
        ufi_pkg::ADDR_IN_EN: st_nxt.in_en_r = i_avs_writedata[3:0];
        ufi_pkg::ADDR_CM_EN: st_nxt.cm_en_r = i_avs_writedata[3:0];
        ufi_pkg::ADDR_CPU_EN: st_nxt.cpu_en_r = i_avs_writedata[0];
        default: st_nxt.cpu_en_r = st_nxt.cpu_en_r;
      endcase
    end
    st_nxt.irq_r = st_nxt.cpu_en_r &&
      (|(st_nxt.in_flags_r & st_nxt.in_en_r) ||
       |(st_nxt.cm_flags_r & st_nxt.cm_en_r));
  end

  // State register with asynchronous reset to constants.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st_r <= '{frame_r: 11'h000, in_flags_r: 4'h0, cm_flags_r: 4'h0,
                in_en_r: ufi_pkg::IN_EN_RST, cm_en_r: ufi_pkg::CM_EN_RST,
                cpu_en_r: ufi_pkg::CPU_EN_RST, rdata_r: 32'h00000000,
                rvalid_r: 1'b0, irq_r: 1'b0};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Outputs come straight from flip-flops; waitrequest is low in the
  // answer cycle only.
  assign o_avs_readdata = st_r.rdata_r;
  assign o_avs_waitrequest = !st_r.rvalid_r;
  assign o_irq = st_r.irq_r;

  // Frame registers follow an SOF one cycle later.
  frame_capt_a:
  assert property (@(posedge i_clk) disable iff (i_rst)
    i_ev.sof |=> st_r.frame_r == $past(i_ev.frame))
  else $error("frame number not captured");

  // SOF sets the common SOF flag.
  sof_flag_a:
  assert property (@(posedge i_clk) disable iff (i_rst)
    i_ev.sof |=> st_r.cm_flags_r[ufi_pkg::SOF_BIT])
  else $error("sof flag not set");

  // Events set IN flags.
  in_set_a:
  assert property (@(posedge i_clk) disable iff (i_rst)
    |i_ev.in_ev |=>
      (st_r.in_flags_r & $past(i_ev.in_ev)) == $past(i_ev.in_ev))
  else $error("in flag not set");

  // Read clears IN flags unless an event arrives.
  rd_clear_a:
  assert property (@(posedge i_clk) disable iff (i_rst)
    rd_hit && i_avs_address == ufi_pkg::ADDR_IN_FLAGS |=>
      st_r.in_flags_r == $past(i_ev.in_ev))
  else $error("read did not clear flags");

  // Writes never change IN flags without IN events.
  wr_noflag_a:
  assert property (@(posedge i_clk) disable iff (i_rst)
    wr_hit && i_ev.in_ev == 4'h0 |=>
      st_r.in_flags_r == $past(st_r.in_flags_r))
  else $error("write altered flags");

  // Enable write lands.
  en_write_a:
  assert property (@(posedge i_clk) disable iff (i_rst)
    wr_hit && i_avs_byteenable[0] && i_avs_address == ufi_pkg::ADDR_IN_EN |=>
      st_r.in_en_r == $past(i_avs_writedata[3:0]))
  else $error("enable write lost");

  // Interrupt follows gated flags.
  irq_gate_a:
  assert property (@(posedge i_clk) disable iff (i_rst)
    o_irq == (st_r.cpu_en_r && (|(st_r.in_flags_r & st_r.in_en_r) ||
      |(st_r.cm_flags_r & st_r.cm_en_r))))
  else $error("irq mismatch");

  // High frame byte upper bits read zero.
  frame_hi_a:
  assert property (@(posedge i_clk) disable iff (i_rst)
    rd_hit && $past(i_avs_address) == ufi_pkg::ADDR_FRAME_HI |->
      o_avs_readdata[31:3] == 29'h0)
  else $error("frame high upper bits set");

  // Enable reset value check after reset.
  en_rst_a:
  assert property (@(posedge i_clk)
    $fell(i_rst) |-> st_r.in_en_r == ufi_pkg::IN_EN_RST)
  else $error("enable reset wrong");

  // Waitrequest is low for one cycle only, so each request is answered
  // once; a request still held after that cycle is taken again as a new one.
  wait_one_a:
  assert property (@(posedge i_clk) disable iff (i_rst)
    !o_avs_waitrequest |=> o_avs_waitrequest)
  else $error("waitrequest low too long");

  // Every register is one byte wide; the upper read bits stay zero.
  rd_upper_a:
  assert property (@(posedge i_clk) disable iff (i_rst)
    o_avs_readdata[31:8] == 24'h000000)
  else $error("upper read data bits set");

  // A read of the IN flags returns the value from before the clear.
  rd_before_a:
  assert property (@(posedge i_clk) disable iff (i_rst)
    i_avs_read && o_avs_waitrequest &&
      i_avs_address == ufi_pkg::ADDR_IN_FLAGS |=>
      o_avs_readdata[3:0] == $past(st_r.in_flags_r))
  else $error("flag read value wrong");

  // The low frame byte reads back the captured frame number.
  frame_rd_a:
  assert property (@(posedge i_clk) disable iff (i_rst)
    i_avs_read && o_avs_waitrequest &&
      i_avs_address == ufi_pkg::ADDR_FRAME_LO |=>
      o_avs_readdata[7:0] == $past(st_r.frame_r[7:0]))
  else $error("frame low read wrong");

  // A read of the common flags clears them unless an event arrives.
  cm_clear_a:
  assert property (@(posedge i_clk) disable iff (i_rst)
    rd_hit && i_avs_address == ufi_pkg::ADDR_CM_FLAGS |=>
      st_r.cm_flags_r == $past({i_ev.sof, i_ev.cm_ev}))
  else $error("common flags not cleared");

  // Without an event or a clearing read the IN flags hold.
  flag_hold_a:
  assert property (@(posedge i_clk) disable iff (i_rst)
    !(rd_hit && i_avs_address == ufi_pkg::ADDR_IN_FLAGS) &&
      i_ev.in_ev == 4'h0 |=> $stable(st_r.in_flags_r))
  else $error("in flags changed alone");

  // The frame number changes only on a start of frame.
  frame_hold_a:
  assert property (@(posedge i_clk) disable iff (i_rst)
    !i_ev.sof |=> $stable(st_r.frame_r))
  else $error("frame changed without sof");

  // A write of the processor-side enable lands.
  cpu_write_a:
  assert property (@(posedge i_clk) disable iff (i_rst)
    wr_hit && i_avs_byteenable[0] &&
      i_avs_address == ufi_pkg::ADDR_CPU_EN |=>
      st_r.cpu_en_r == $past(i_avs_writedata[0]))
  else $error("cpu enable write lost");

  // Main scenarios that the bench is meant to reach.
  cov_sof_c: cover property (@(posedge i_clk) disable iff (i_rst) i_ev.sof);
  cov_wr_c: cover property (@(posedge i_clk) disable iff (i_rst)
    wr_hit && i_avs_address == ufi_pkg::ADDR_IN_EN);
  cov_irq_c: cover property (@(posedge i_clk) disable iff (i_rst) $rose(o_irq));
  cov_clr_c: cover property (@(posedge i_clk) disable iff (i_rst)
    rd_hit && i_avs_address == ufi_pkg::ADDR_IN_FLAGS && |st_r.in_flags_r);
endmodule : ufi_core

// *** verif/ufi_host_model.sv ***
// Behavioural USB host that issues frame and endpoint events.
`timescale 1ns/10ps
module ufi_host_model
(
  input wire logic i_clk,
  output ufi_pkg::ufi_events_t o_ev
);
  // The link is quiet until a task asks for an event.
  initial o_ev = '0;
  // One cycle event; afterwards the stale frame field shows its inverse.
  task automatic send(input logic s, input logic [10:0] f,
                      input logic [3:0] e);
    @(posedge i_clk);
    o_ev <= {s, f, e, 3'h0};
    @(posedge i_clk);
    o_ev <= {1'h0, ~f, 4'h0, 3'h0};
  endtask : send
endmodule : ufi_host_model

// *** verif/usb_frame_number_and_irq_flags_tb_top.sv ***
// Self-checking bench for frame capture and USB interrupt flags.
`timescale 1ns/10ps
module usb_frame_number_and_irq_flags_tb_top;
  logic i_clk, i_rst, rd, wr, wreq, irq;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, d;
  ufi_pkg::ufi_events_t ev;
  int n_fail, cmp_count;
  int cyc = 0;
  ufi_core u_ufi_core (.i_clk(i_clk), .i_rst(i_rst), .i_ev(ev),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wdat), .i_avs_byteenable(4'hF),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .o_irq(irq));
  ufi_host_model u_host (.i_clk(i_clk), .o_ev(ev));
  // Clock of 5 ns period.
  initial
  begin
    i_clk = 1'h0;
    forever #2.5 i_clk = ~i_clk;
  end
  // Compare and count; a mismatch is reported at once.
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // One Avalon transfer, held until waitrequest is seen low.
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [7:0] v);
    @(posedge i_clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wdat <= {24'h0, v};
    do @(posedge i_clk); while (wreq !== 1'h0);
    d = rdat;
    rd <= 1'h0;
    wr <= 1'h0;
  endtask : acc
  // Read a register and compare its byte.
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    acc(1'h0, a, 8'h00);
    chk(d, {24'h0, e});
  endtask : rchk
  // Let the registered interrupt settle, then compare it.
  task automatic ichk(input logic e);
    repeat (3) @(posedge i_clk);
    chk({31'h0, irq}, {31'h0, e});
  endtask : ichk
  // Print the counts and the verdict, then end the run.
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test
  // Cut a hang short.
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_fail++;
      stop_test();
    end
  end
  // Main sequence of register and event checks.
  initial
  begin
    i_rst = 1'h1;
    {rd, wr, adr, wdat, n_fail, cmp_count} = '0;
    repeat (10) @(posedge i_clk);
    i_rst <= 1'h0;
    rchk(8'h02, 8'h00);
    rchk(8'h0C, 8'h00);
    rchk(8'h0D, 8'h00);
    rchk(8'h07, 8'h0F);
    rchk(8'h20, 8'h00);
    u_host.send(1'h1, 11'h5A3, 4'h0);
    rchk(8'h0C, 8'hA3);
    rchk(8'h0D, 8'h05);
    acc(1'h1, 8'h0D, 8'hFF);
    rchk(8'h0D, 8'h05);
    u_host.send(1'h1, 11'h7FF, 4'h0);
    ichk(1'h0);
    rchk(8'h0C, 8'hFF);
    rchk(8'h0D, 8'h07);
    rchk(8'h06, 8'h08);
    rchk(8'h06, 8'h00);
    // Each IN source alone, with a write that must not clear it.
    for (int i = 0; i < 4; i++)
    begin
      u_host.send(1'h0, 11'h000, 4'(1 << i));
      acc(1'h1, 8'h02, 8'h00);
      rchk(8'h02, 8'(1 << i));
      rchk(8'h02, 8'h00);
    end
    acc(1'h1, 8'h10, 8'h01);
    u_host.send(1'h0, 11'h000, 4'h4);
    ichk(1'h1);
    acc(1'h1, 8'h07, 8'h00);
    ichk(1'h0);
    acc(1'h1, 8'h07, 8'h0F);
    ichk(1'h1);
    rchk(8'h02, 8'h04);
    ichk(1'h0);
    stop_test();
  end
endmodule : usb_frame_number_and_irq_flags_tb_top
